// File: verilog/smk_unlock.sv
// Security mode controller: key unlock, key update and access gating
// Function
// - Each step up in mode needs its own two-word key pair on the control port; i_seal_req seals.
// - Both key words must arrive back to back, nothing written between.
// - Sealed flag reads one whenever the block is sealed.
// - Correct unseal pair clears sealed flag and enters unsealed.
// - Correct full-access pair clears full-access locked flag, enters full access.
// - Each stored key holds two words: key 1 first, key 0 second.
// - Control port key words are byte swapped against their read-back order.
// - Stored keys may be rewritten only in full access; rejected otherwise.
// - Full access and unsealed give equal storage rights, except key writes.
// - Parameters sit at subclass and offset with default, minimum, maximum.
// - Sealed: block A read only, B and C read/write, parameters closed.
// - Mode sets rights; unsealed and full access allow read/write everywhere.
`timescale 1ns/1ps
`default_nettype none
module smk_unlock
    import smk_pkg::*;
(
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    // Control command port
    input  wire logic              i_ctl_wr,
    input  wire logic [KEY_W-1:0]  i_ctl_word,
    input  wire logic              i_seal_req,
    // Key update
    input  wire logic              i_key_wr,
    input  wire logic              i_key_sel,
    input  wire logic [PAIR_W-1:0] i_key_data,
    // Manufacturer block and storage access check
    input  wire logic              i_acc_req,
    input  wire logic [1:0]        i_acc_tgt,
    input  wire logic              i_acc_wr,
    // Parameter access
    input  wire logic              i_par_req,
    input  wire logic              i_par_wr,
    input  wire logic [7:0]        i_par_sub,
    input  wire logic [7:0]        i_par_off,
    input  wire logic [15:0]       i_par_data,
    // Status
    output logic [2:0]             o_mode,
    output logic                   o_sealed_flag,
    output logic                   o_full_access_locked_flag,
    output logic [PAIR_W-1:0]      o_unseal_key,
    output logic [PAIR_W-1:0]      o_full_key,
    // Answers
    output logic                   o_key_ack,
    output logic                   o_key_rej,
    output logic                   o_acc_grant,
    output logic                   o_acc_deny,
    output logic                   o_par_ok,
    output logic                   o_par_err,
    output logic [15:0]            o_par_rdata
);

    smk_pair_if pif ();

    assign pif.wr   = i_ctl_wr;
    assign pif.word = i_ctl_word;

    smk_key_pair u_pair (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .pif       (pif.tracker)
    );

    // ****************************************
    // Mode and key state
    // ****************************************
    smk_mode_t         mode;
    smk_mode_t         next_mode;
    logic [PAIR_W-1:0] unseal_key;
    logic [PAIR_W-1:0] next_unseal_key;
    logic [PAIR_W-1:0] full_key;
    logic [PAIR_W-1:0] next_full_key;
    logic              key_ack;
    logic              next_key_ack;
    logic              key_rej;
    logic              next_key_rej;
    logic              clr;
    logic              next_clr;
    logic              locked_flag;
    logic              next_locked_flag;

    assign pif.clr = clr;

    always_comb begin
        next_mode       = mode;
        next_unseal_key = unseal_key;
        next_full_key   = full_key;
        next_key_ack    = 1'b0;
        next_key_rej    = 1'b0;
        next_clr        = 1'b0;
        if (pif.pair_vld) begin
            unique case (mode)
                SMK_SEALED: begin
                    if (pif.pair == unseal_key) begin
                        next_mode = SMK_UNSEALED;
                        next_clr  = 1'b1;
                    end
                end
                SMK_UNSEALED: begin
                    if (pif.pair == full_key) begin
                        next_mode = SMK_FULL;
                        next_clr  = 1'b1;
                    end
                end
                SMK_FULL: next_mode = mode;
            endcase
        end
        // Explicit seal overrides a pair landing in the same cycle
        if (i_seal_req) begin
            next_mode = SMK_SEALED;
        end
        next_locked_flag = (next_mode != SMK_FULL);
        if (i_key_wr) begin
            if (mode == SMK_FULL) begin
                next_key_ack = 1'b1;
                if (i_key_sel == KEY_SEL_FULL) begin
                    next_full_key = i_key_data;
                end else begin
                    next_unseal_key = i_key_data;
                end
            end else begin
                next_key_rej = 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            mode       <= SMK_SEALED;
            unseal_key <= UNSEAL_KEY_RST;
            full_key   <= FULL_KEY_RST;
            key_ack    <= 1'b0;
            key_rej    <= 1'b0;
            clr        <= 1'b0;
            locked_flag <= 1'b1;
        end else begin
            mode       <= next_mode;
            unseal_key <= next_unseal_key;
            full_key   <= next_full_key;
            key_ack    <= next_key_ack;
            key_rej    <= next_key_rej;
            clr        <= next_clr;
            locked_flag <= next_locked_flag;
        end
    end

    // ****************************************
    // Access gating and parameter table
    // ****************************************
    // Table lives in flops: a sealed part never reaches it; reset restores
    // defaults, and an unsealed or full-access write can put back any in-range value.
    logic [15:0] par_mem [PAR_N];
    logic [15:0] next_par_mem [PAR_N];
    logic        acc_grant;
    logic        next_acc_grant;
    logic        acc_deny;
    logic        next_acc_deny;
    logic        par_ok;
    logic        next_par_ok;
    logic        par_err;
    logic        next_par_err;
    logic [15:0] par_rdata;
    logic [15:0] next_par_rdata;

    always_comb begin
        logic found;
        int   idx;
        found          = 1'b0;
        idx            = 0;
        next_par_mem   = par_mem;
        next_acc_grant = 1'b0;
        next_acc_deny  = 1'b0;
        next_par_ok    = 1'b0;
        next_par_err   = 1'b0;
        next_par_rdata = par_rdata;
        if (i_acc_req) begin
            if (mode != SMK_SEALED) begin
                next_acc_grant = 1'b1;
            end else if (i_acc_tgt == TGT_DF || (i_acc_tgt == TGT_MIA && i_acc_wr)) begin
                next_acc_deny = 1'b1;
            end else begin
                next_acc_grant = 1'b1;
            end
        end
        for (int k = 0; k < PAR_N; k++) begin
            if (PAR_SUB[k] == i_par_sub && PAR_OFF[k] == i_par_off) begin
                found = 1'b1;
                idx   = k;
            end
        end
        if (i_par_req) begin
            if (mode == SMK_SEALED || !found) begin
                next_par_err = 1'b1;
            end else if (!i_par_wr) begin
                next_par_ok    = 1'b1;
                next_par_rdata = par_mem[idx];
            end else if (i_par_data >= PAR_MIN[idx] && i_par_data <= PAR_MAX[idx]) begin
                next_par_ok       = 1'b1;
                next_par_mem[idx] = i_par_data;
            end else begin
                next_par_err = 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            par_mem   <= PAR_DEF;
            acc_grant <= 1'b0;
            acc_deny  <= 1'b0;
            par_ok    <= 1'b0;
            par_err   <= 1'b0;
            par_rdata <= '0;
        end else begin
            par_mem   <= next_par_mem;
            acc_grant <= next_acc_grant;
            acc_deny  <= next_acc_deny;
            par_ok    <= next_par_ok;
            par_err   <= next_par_err;
            par_rdata <= next_par_rdata;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_mode                    = mode;
    assign o_sealed_flag             = mode[0];
    assign o_full_access_locked_flag = locked_flag;
    assign o_unseal_key              = unseal_key;
    assign o_full_key                = full_key;
    assign o_key_ack                 = key_ack;
    assign o_key_rej                 = key_rej;
    assign o_acc_grant               = acc_grant;
    assign o_acc_deny                = acc_deny;
    assign o_par_ok                  = par_ok;
    assign o_par_err                 = par_err;
    assign o_par_rdata               = par_rdata;

    // ****************************************
    // Assertions
    // ****************************************
    sequence unseal_pair_s;
        pif.pair_vld && mode == SMK_SEALED && pif.pair == unseal_key && !i_seal_req;
    endsequence

    sequence full_pair_s;
        pif.pair_vld && mode == SMK_UNSEALED && pif.pair == full_key && !i_seal_req;
    endsequence

    sealed_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        mode == SMK_SEALED |-> o_sealed_flag && o_full_access_locked_flag)
        else $error("Sealed without sealed flag");

    unseal_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        unseal_pair_s |=> !o_sealed_flag && mode == SMK_UNSEALED)
        else $error("Unseal pair did not unseal");

    full_entry_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        full_pair_s |=> !o_full_access_locked_flag && mode == SMK_FULL)
        else $error("Full-access pair did not open full access");

    bad_pair_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        pif.pair_vld && pif.pair != unseal_key && pif.pair != full_key && !i_seal_req
            |=> $stable(mode))
        else $error("Wrong key pair changed the mode");

    key_reject_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_key_wr && mode != SMK_FULL |=> o_key_rej && !o_key_ack
            && $stable(unseal_key) && $stable(full_key))
        else $error("Key update outside full access");

    key_accept_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_key_wr && mode == SMK_FULL && i_key_sel == KEY_SEL_UNSEAL
            |=> o_key_ack && o_unseal_key == $past(i_key_data))
        else $error("Key update in full access lost");

    block_a_ro_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_acc_req && mode == SMK_SEALED && i_acc_tgt == TGT_MIA && i_acc_wr
            |=> o_acc_deny && !o_acc_grant)
        else $error("Block A written while sealed");

    sealed_store_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_par_req && mode == SMK_SEALED |=> o_par_err && !o_par_ok)
        else $error("Parameter access while sealed");

    open_rights_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_acc_req && mode != SMK_SEALED |=> o_acc_grant && !o_acc_deny)
        else $error("Access refused while open");

endmodule
`default_nettype wire

// File: verilog/smk_pkg.sv
// Constants, types and helpers for the security mode key unlock block
package smk_pkg;

    // ****************************************
    // Widths and field positions
    // ****************************************
    localparam int KEY_W     = 16;
    localparam int PAIR_W    = 32;
    localparam int KEY1_LSB  = 0;
    localparam int KEY0_LSB  = 16;
    localparam int BYTE_W    = 8;

    // ****************************************
    // Modes, one-hot
    // ****************************************
    typedef enum logic [2:0] {
        SMK_SEALED   = 3'h1,
        SMK_UNSEALED = 3'h2,
        SMK_FULL     = 3'h4
    } smk_mode_t;

    // ****************************************
    // Access targets and key selects
    // ****************************************
    localparam logic [1:0] TGT_DF  = 2'h0;
    localparam logic [1:0] TGT_MIA = 2'h1;
    localparam logic [1:0] TGT_MIB = 2'h2;
    localparam logic [1:0] TGT_MIC = 2'h3;

    localparam logic KEY_SEL_UNSEAL = 1'h0;
    localparam logic KEY_SEL_FULL   = 1'h1;

    // Reset images of the stored keys; values are arbitrary
    localparam logic [PAIR_W-1:0] UNSEAL_KEY_RST = 32'h1111_2222;
    localparam logic [PAIR_W-1:0] FULL_KEY_RST   = 32'h3333_4444;

    // ****************************************
    // Parameter table: subclass, offset, limits, default
    // ****************************************
    localparam int PAR_N = 4;
    typedef logic [7:0]  smk_b8_t;
    typedef logic [15:0] smk_w16_t;
    localparam smk_b8_t  PAR_SUB [PAR_N] = '{8'h02, 8'h22, 8'h30, 8'h30};
    localparam smk_b8_t  PAR_OFF [PAR_N] = '{8'h00, 8'h02, 8'h17, 8'h11};
    localparam smk_w16_t PAR_MIN [PAR_N] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    localparam smk_w16_t PAR_MAX [PAR_N] = '{16'h04b0, 16'h11f8, 16'h7fff, 16'hffff};
    localparam smk_w16_t PAR_DEF [PAR_N] = '{16'h0226, 16'h1068, 16'h03e8, 16'h0000};

    // Control port words arrive with their bytes swapped
    function automatic logic [KEY_W-1:0] byte_swap(input logic [KEY_W-1:0] w);
        return {w[BYTE_W-1:0], w[KEY_W-1:BYTE_W]};
    endfunction

endpackage

// File: verilog/smk_pair_if.sv
// Carrier between the control write tracker and the mode controller
`timescale 1ns/1ps
`default_nettype none
interface smk_pair_if;
    import smk_pkg::*;
    logic              wr;
    logic [KEY_W-1:0]  word;
    logic              clr;
    logic              pair_vld;
    logic [PAIR_W-1:0] pair;

    modport tracker (input wr, input word, input clr, output pair_vld, output pair);
    modport user    (output wr, output word, output clr, input pair_vld, input pair);
endinterface
`default_nettype wire

// File: verilog/smk_key_pair.sv
// Pairs consecutive control writes into candidate key words
`timescale 1ns/1ps
`default_nettype none
module smk_key_pair
    import smk_pkg::*;
(
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    // Pair stream
    smk_pair_if.tracker     pif
);

    logic              have_first;
    logic              next_have_first;
    logic [KEY_W-1:0]  first_word;
    logic [KEY_W-1:0]  next_first_word;
    logic              pair_vld;
    logic              next_pair_vld;
    logic [PAIR_W-1:0] pair;
    logic [PAIR_W-1:0] next_pair;

    // ****************************************
    // Sliding pair window
    // ****************************************
    // Each write pairs with the one just before it unless reset or an unlock cleared it,
    // so any other write between two key words breaks the pair on its own.
    always_comb begin
        next_have_first = have_first;
        next_first_word = first_word;
        next_pair_vld   = 1'b0;
        next_pair       = pair;
        if (pif.clr) begin
            next_have_first = 1'b0;
        end
        if (pif.wr) begin
            if (have_first && !pif.clr) begin
                next_pair_vld = 1'b1;
                next_pair[KEY1_LSB +: KEY_W] = byte_swap(first_word);
                next_pair[KEY0_LSB +: KEY_W] = byte_swap(pif.word);
            end
            next_have_first = 1'b1;
            next_first_word = pif.word;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            have_first <= 1'b0;
            first_word <= '0;
            pair_vld   <= 1'b0;
            pair       <= '0;
        end else begin
            have_first <= next_have_first;
            first_word <= next_first_word;
            pair_vld   <= next_pair_vld;
            pair       <= next_pair;
        end
    end

    assign pif.pair_vld = pair_vld;
    assign pif.pair     = pair;

    back_to_back_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        pif.wr && have_first && !pif.clr |=> pif.pair_vld
            && pif.pair[KEY0_LSB +: KEY_W] == byte_swap($past(pif.word)))
        else $error("Consecutive writes did not form a pair");

    no_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !pif.wr |=> !pif.pair_vld)
        else $error("Pair seen without a control write");

endmodule
`default_nettype wire

// File: verif/smk_host_model.sv
// Host model that writes key pairs to the control command port
`timescale 1ns/1ps
`default_nettype none
module smk_host_model
    import smk_pkg::*;
(
    // Clock
    input  wire logic         i_ref_clk,
    // Control command port
    output logic              o_ctl_wr,
    output logic [KEY_W-1:0]  o_ctl_word
);
    initial begin
        o_ctl_wr   = 1'b0;
        o_ctl_word = 16'h0000;
    end

    function automatic logic [KEY_W-1:0] swp(input logic [KEY_W-1:0] w);
        return {w[7:0], w[15:8]};
    endfunction

    // Released port shows the inverse word, never a stale copy
    task automatic put_word(input logic [KEY_W-1:0] w);
        @(negedge i_ref_clk);
        o_ctl_wr   = 1'b1;
        o_ctl_word = w;
        @(negedge i_ref_clk);
        o_ctl_wr   = 1'b0;
        o_ctl_word = ~w;
    endtask

    // How: 0 proper, 1 key 0 first, 2 bytes unswapped, 3 write in between
    task automatic send_pair(input logic [PAIR_W-1:0] key, input int how);
        logic [KEY_W-1:0] k1;
        logic [KEY_W-1:0] k0;
        k1 = swp(key[KEY1_LSB +: KEY_W]);
        k0 = swp(key[KEY0_LSB +: KEY_W]);
        if (how == 2) begin
            k1 = key[KEY1_LSB +: KEY_W];
            k0 = key[KEY0_LSB +: KEY_W];
        end
        if (how == 1) begin
            put_word(k0);
            put_word(k1);
        end else begin
            put_word(k1);
            if (how == 3) begin
                put_word(16'h00a5);
            end
            put_word(k0);
        end
    endtask
endmodule
`default_nettype wire

// File: verif/smk_unlock_tb.sv
// Self-checking testbench for the security mode controller
`timescale 1ns/1ps
`default_nettype none
module smk_unlock_tb;
    import smk_pkg::*;
    logic              i_ref_clk;
    logic              i_rst;
    logic              ctl_wr;
    logic [KEY_W-1:0]  ctl_word;
    logic              seal_req;
    logic              key_wr;
    logic              key_sel;
    logic [PAIR_W-1:0] key_data;
    logic              acc_req;
    logic [1:0]        acc_tgt;
    logic              acc_wr;
    logic              par_req;
    logic              par_wr;
    logic [7:0]        par_sub;
    logic [7:0]        par_off;
    logic [15:0]       par_data;
    logic [2:0]        mode;
    logic              sealed_flag;
    logic              locked_flag;
    logic [PAIR_W-1:0] unseal_key;
    logic [PAIR_W-1:0] full_key;
    logic              key_ack;
    logic              key_rej;
    logic              acc_grant;
    logic              acc_deny;
    logic              par_ok;
    logic              par_err;
    logic [15:0]       par_rdata;
    int                bad_count;
    int                n_tests;
    // New key avoids every subcommand code
    localparam logic [PAIR_W-1:0] NEW_KEY = 32'h9abc_def0;
    localparam logic [PAIR_W-1:0] NEW_FULL = 32'h7e81_6d92;

    smk_host_model host (.i_ref_clk(i_ref_clk), .o_ctl_wr(ctl_wr), .o_ctl_word(ctl_word));

    smk_unlock dut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ctl_wr(ctl_wr), .i_ctl_word(ctl_word),
        .i_seal_req(seal_req), .i_key_wr(key_wr), .i_key_sel(key_sel),
        .i_key_data(key_data), .i_acc_req(acc_req), .i_acc_tgt(acc_tgt),
        .i_acc_wr(acc_wr), .i_par_req(par_req), .i_par_wr(par_wr), .i_par_sub(par_sub),
        .i_par_off(par_off), .i_par_data(par_data), .o_mode(mode),
        .o_sealed_flag(sealed_flag), .o_full_access_locked_flag(locked_flag),
        .o_unseal_key(unseal_key), .o_full_key(full_key), .o_key_ack(key_ack),
        .o_key_rej(key_rej), .o_acc_grant(acc_grant), .o_acc_deny(acc_deny),
        .o_par_ok(par_ok), .o_par_err(par_err), .o_par_rdata(par_rdata)
    );

    // ****************************************
    // Clock, compares and bus tasks
    // ****************************************
    initial i_ref_clk = 1'b0;
    always #25 i_ref_clk = ~i_ref_clk;

    task automatic check_bit(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    task automatic check_mode(input logic [2:0] m);
        repeat (3) @(negedge i_ref_clk);
        check_word("mode", {29'h0, m}, {29'h0, mode});
        check_bit("sealed flag", m == SMK_SEALED, sealed_flag);
        check_bit("locked flag", m != SMK_FULL, locked_flag);
    endtask

    task automatic key_update(input logic sel, input logic [31:0] d, input logic ok);
        @(negedge i_ref_clk);
        {key_wr, key_sel, key_data} = {1'b1, sel, d};
        @(negedge i_ref_clk);
        key_wr = 1'b0;
        check_bit("key ack", ok, key_ack);
        check_bit("key rej", !ok, key_rej);
    endtask

    task automatic access(input logic [1:0] tgt, input logic wr, input logic ok);
        @(negedge i_ref_clk);
        {acc_req, acc_tgt, acc_wr} = {1'b1, tgt, wr};
        @(negedge i_ref_clk);
        acc_req = 1'b0;
        check_bit("grant", ok, acc_grant);
        check_bit("deny", !ok, acc_deny);
    endtask

    task automatic par(input logic wr, input logic [15:0] loc, input logic [15:0] d,
                       input logic ok, input logic [15:0] rd);
        @(negedge i_ref_clk);
        {par_req, par_wr, par_sub, par_off, par_data} = {1'b1, wr, loc, d};
        @(negedge i_ref_clk);
        par_req = 1'b0;
        check_bit("par ok", ok, par_ok);
        check_bit("par err", !ok, par_err);
        if (ok && !wr) begin
            check_word("par rdata", {16'h0, rd}, {16'h0, par_rdata});
        end
    endtask

    task automatic all_access(input logic sealed);
        for (int t = 0; t < 4; t++) begin
            for (int w = 0; w < 2; w++) begin
                access(t[1:0], w[0], !sealed || t >= 2 || (t == 1 && w == 0));
            end
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset_and_sealed;
        check_mode(SMK_SEALED);
        check_word("unseal key", UNSEAL_KEY_RST, unseal_key);
        check_word("full key", FULL_KEY_RST, full_key);
        all_access(1'b1);
        par(1'b0, 16'h0200, 16'h0, 1'b0, 16'h0);
        key_update(KEY_SEL_UNSEAL, NEW_KEY, 1'b0);
    endtask

    // Wrong key, wrong order and broken pairs all leave sealed mode alone
    task automatic test_bad_pairs;
        host.send_pair(FULL_KEY_RST, 0);
        check_mode(SMK_SEALED);
        host.send_pair(UNSEAL_KEY_RST, 1);
        check_mode(SMK_SEALED);
        host.send_pair(UNSEAL_KEY_RST, 3);
        check_mode(SMK_SEALED);
    endtask

    task automatic test_unsealed;
        host.send_pair(UNSEAL_KEY_RST, 0);
        check_mode(SMK_UNSEALED);
        all_access(1'b0);
        par(1'b0, 16'h0200, 16'h0, 1'b1, 16'h0226);
        par(1'b1, 16'h0200, 16'h04b0, 1'b1, 16'h0);
        par(1'b1, 16'h0200, 16'h04b1, 1'b0, 16'h0);
        par(1'b0, 16'h0201, 16'h0, 1'b0, 16'h0);
        par(1'b0, 16'h3011, 16'h0, 1'b1, 16'h0000);
        par(1'b0, 16'h0200, 16'h0, 1'b1, 16'h04b0);
        key_update(KEY_SEL_UNSEAL, NEW_KEY, 1'b0);
        host.send_pair(UNSEAL_KEY_RST, 0);
        check_mode(SMK_UNSEALED);
    endtask

    task automatic test_full_and_rekey;
        host.send_pair(FULL_KEY_RST, 0);
        check_mode(SMK_FULL);
        all_access(1'b0);
        key_update(KEY_SEL_UNSEAL, NEW_KEY, 1'b1);
        check_word("unseal key", NEW_KEY, unseal_key);
        key_update(KEY_SEL_FULL, NEW_FULL, 1'b1);
        check_word("full key", NEW_FULL, full_key);
        @(negedge i_ref_clk);
        seal_req = 1'b1;
        @(negedge i_ref_clk);
        seal_req = 1'b0;
        check_mode(SMK_SEALED);
        host.send_pair(UNSEAL_KEY_RST, 0);
        check_mode(SMK_SEALED);
        host.send_pair(NEW_KEY, 2);
        check_mode(SMK_SEALED);
        host.send_pair(NEW_KEY, 0);
        check_mode(SMK_UNSEALED);
        host.send_pair(NEW_FULL, 0);
        check_mode(SMK_FULL);
    endtask

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        bad_count = 0;
        n_tests   = 0;
        i_rst     = 1'b1;
        {seal_req, key_wr, key_sel, key_data} = '0;
        {acc_req, acc_tgt, acc_wr} = '0;
        {par_req, par_wr, par_sub, par_off, par_data} = '0;
        repeat (20) @(negedge i_ref_clk);
        i_rst = 1'b0;
        test_reset_and_sealed();
        test_bad_pairs();
        test_unsealed();
        test_full_and_rekey();
        complete_run();
    end

    // Whole run takes well under 600 cycles
    initial begin
        repeat (3000) @(posedge i_ref_clk);
        bad_count++;
        complete_run();
    end
endmodule
`default_nettype wire
